// *** shared/adc_link_pkg.sv ***
/*
  Constants and types shared by both ends of the converter result link.
  Assumes a 100 MHz mclk on both ends and one link interface between them.
*/
// =====================================================================
// Contract
// - Byte format: address bit selects high byte
// - One read starts conversion, returns result
// - Busy with select stalls the first read
// - Second byte read runs without wait
// - Low eight bits first, upper bits next
// - Byte format: serial pins idle between conversions
// - Gated clock: data valid at first fall
// - Serial bits shift out during conversion
// - Serial word is sixteen bits long
// - Continuous clock: strobe marks valid data
// - Receiver samples on falling serial clock
// - Gated clock needs a gated-capable receiver
// - Convert start may come asynchronously
// - Standalone select pulse outlasts conversion
// - Busy drives read; latch on busy rise
// - Low byte fetched first in that mode
// - No read while a conversion runs
package adc_link_pkg;

  // =====================================================================
  // Timing
  localparam int CLK_NS = 10;
  localparam int CONV_NS = 8000;
  localparam int CONV_CYC = CONV_NS / CLK_NS;
  localparam int CONV_W = $clog2(CONV_CYC + 1);
  localparam int SCLK_HALF_NS = 60;
  localparam int SCLK_HALF_CYC =
    (SCLK_HALF_NS / CLK_NS < 1) ? 1 : SCLK_HALF_NS / CLK_NS;
  localparam int SCLK_DIV_W = $clog2(SCLK_HALF_CYC + 1);
  localparam int CVT_PULSE_NS = 100;
  localparam int CVT_PULSE_CYC = (CVT_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int READ_SETUP_NS = 100;
  localparam int READ_SETUP_CYC = (READ_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETTLE_NS = 50;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_NS = 50;
  localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int ALONE_CS_NS = 9000;
  localparam int ALONE_CS_CYC = (ALONE_CS_NS + CLK_NS - 1) / CLK_NS;
  localparam int TMR_W = 10;

  // =====================================================================
  // Data widths
  localparam int RES_BITS = 12;
  localparam int WORD_BITS = 16;
  localparam int BYTE_BITS = 8;

  // Format select levels: 0 V, +5 V, -5 V
  typedef enum logic [1:0] {
    FMT_BYTE = 2'b00,
    FMT_WORD = 2'b01,
    FMT_CONT = 2'b10
  } fmt_e;

  // Host operations
  typedef enum logic [1:0] {
    OP_BYTE_READ = 2'b00,
    OP_PULSE = 2'b01,
    OP_ALONE = 2'b10
  } op_e;

  // =====================================================================
  // Host register map, word index
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_STATUS = 3'h1;
  localparam logic [2:0] REG_RESULT = 3'h2;
  localparam logic [2:0] REG_SERIAL = 3'h3;
  localparam logic [2:0] REG_IRQ_STAT = 3'h4;
  localparam logic [2:0] REG_IRQ_MASK = 3'h5;
  localparam int CTRL_FMT_LSB = 0;
  localparam int CTRL_GO_BIT = 2;
  localparam int CTRL_OP_LSB = 4;
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_CONV_BIT = 1;
  localparam int IRQ_PAR_BIT = 0;
  localparam int IRQ_SER_BIT = 1;
  localparam logic [1:0] RST_FMT = 2'h0;
  localparam logic [1:0] RST_OP = 2'h0;
  localparam logic [1:0] RST_MASK = 2'h0;

endpackage

// *** shared/adc_link_if.sv ***
/*
  Pin-level link between the converter end and the host end.
  Assumes pull-ups on open-drain and three-state lines; no clocking here.
*/
interface adc_link_if;

  // =====================================================================
  // Host-driven lines
  logic cs_n;
  logic rd_n;
  logic convert_start_n;
  logic [1:0] fmt_sel;
  logic high_byte_select_o;
  logic high_byte_select_oe;

  // =====================================================================
  // Converter-driven lines
  logic conv_busy_n;
  logic [10:0] result_low_o;
  logic result_low_oe;
  logic result_msb_o;
  logic result_msb_oe;
  logic serial_clk_o;
  logic serial_clk_oe;
  logic serial_data_out;
  logic serial_data_out_oe;
  logic serial_strobe_o;
  logic serial_strobe_oe;

  // Resolved wire levels, pulled high when undriven
  wire msb_or_byte_select_pin;
  wire [11:0] parallel_result_bus;
  wire serial_clk;
  wire serial_data_pin;
  wire serial_strobe_n;

  assign msb_or_byte_select_pin = result_msb_oe ? result_msb_o :
    (high_byte_select_oe ? high_byte_select_o : 1'b1);
  assign parallel_result_bus = {msb_or_byte_select_pin,
    (result_low_oe ? result_low_o : 11'h7ff)};
  assign serial_clk = serial_clk_oe ? serial_clk_o : 1'b1;
  assign serial_data_pin = serial_data_out_oe ? serial_data_out : 1'b1;
  assign serial_strobe_n = serial_strobe_oe ? serial_strobe_o : 1'b1;

  modport dev (
    input cs_n, rd_n, convert_start_n, fmt_sel, msb_or_byte_select_pin,
    output conv_busy_n, result_low_o, result_low_oe, result_msb_o,
    output result_msb_oe, serial_clk_o, serial_clk_oe, serial_data_out,
    output serial_data_out_oe, serial_strobe_o, serial_strobe_oe
  );

  modport host (
    output cs_n, rd_n, convert_start_n, fmt_sel,
    output high_byte_select_o, high_byte_select_oe,
    input conv_busy_n, parallel_result_bus, serial_clk,
    input serial_data_pin, serial_strobe_n
  );

endinterface

// *** hdl/sync2.sv ***
/*
  Two flip-flop synchroniser for levels from another clock domain.
  Assumes the caller reads only q; resets every stage to ones.
*/
module sync2 #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // Two stages, first read by second only
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta_q <= '1;
      q <= '1;
    end else if (ce) begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

// *** hdl/adc_device_end.sv ***
/*
  Converter end: conversion timing, parallel result output in word or
  byte format, and serial result output with gated or free clock.
  Assumes host-driven pins are asynchronous to mclk; sample is the
  digitised input, valid at the moment a conversion starts.
*/
module adc_device_end
  import adc_link_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  adc_link_if.dev link,
  input wire logic [RES_BITS-1:0] sample,
  output logic conversion_active
);

  // =====================================================================
  // Conversion states
  typedef enum logic [1:0] {
    CS_IDLE = 2'b00,
    CS_CONV = 2'b01,
    CS_DONE = 2'b10
  } conv_state_e;

  conv_state_e state_q;
  conv_state_e state_d;
  logic [5:0] pin_s;
  logic cs_prev_q;
  logic cvt_prev_q;
  logic [CONV_W-1:0] cnt_q;
  logic [RES_BITS-1:0] hold_q;
  logic [RES_BITS-1:0] result_q;
  logic busy_n_q;
  logic act_q;
  logic [10:0] low_q;
  logic low_oe_q;
  logic msb_q;
  logic msb_oe_q;
  logic [SCLK_DIV_W-1:0] div_q;
  logic sclk_q;
  logic ser_act_q;
  logic ser_pend_q;
  logic [3:0] bit_q;
  logic [WORD_BITS-1:0] shreg_q;
  logic serial_data_pin_q;
  logic strb_q;
  logic sclk_o_q;
  logic sclk_oe_q;
  logic sdo_q;
  logic sdo_oe_q;
  logic strb_o_q;
  logic strb_oe_q;

  // =====================================================================
  // Pin synchronisation
  // async start tolerated
  sync2 #(.W(6)) u_pin_sync (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .d({link.cs_n, link.rd_n, link.convert_start_n,
        link.msb_or_byte_select_pin, link.fmt_sel}),
    .q(pin_s)
  );

  // Decoded pin levels
  wire cs_s = ~pin_s[5];
  wire rd_s = ~pin_s[4];
  wire cvt_n_s = pin_s[3];
  wire hbs_s = pin_s[2];
  wire [1:0] fmt_s = pin_s[1:0];
  wire byte_fmt = fmt_s == FMT_BYTE;
  wire cont_fmt = fmt_s == FMT_CONT;
  wire idle = state_q == CS_IDLE;

  // Start sources: convert pin rise, or select fall (with low byte selected in byte format) when pin held low
  wire mode2 = ~cvt_n_s;
  wire cvt_rise = cvt_n_s & ~cvt_prev_q;
  wire cs_fall = cs_s & ~cs_prev_q;
  wire low_byte_sel = ~byte_fmt | ~hbs_s;
  wire start = idle & ((~mode2 & cvt_rise) |
    (mode2 & cs_fall & low_byte_sel));

  // =====================================================================
  // Conversion sequencer
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      CS_IDLE: begin
        if (start) begin
          state_d = CS_CONV;
        end
      end
      CS_CONV: begin
        if (cnt_q == '0) begin
          state_d = CS_DONE;
        end
      end
      CS_DONE: begin
        state_d = CS_IDLE;
      end
      default: begin
        state_d = CS_IDLE;
      end
    endcase
  end

  // Edge history of start pins
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cs_prev_q <= 1'b0;
      cvt_prev_q <= 1'b1;
    end else if (ce) begin
      cs_prev_q <= cs_s;
      cvt_prev_q <= cvt_n_s;
    end
  end

  // Timer, hold and result registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= CS_IDLE;
      cnt_q <= '0;
      hold_q <= '0;
      result_q <= '0;
    end else if (ce) begin
      state_q <= state_d;
      if (start) begin
        cnt_q <= CONV_W'(CONV_CYC - 2);
        hold_q <= sample;
      end else if (cnt_q != '0) begin
        cnt_q <= cnt_q - 1'b1;
      end
      if (state_q == CS_CONV && cnt_q == '0) begin
        result_q <= hold_q;
      end
    end
  end

  // Busy line: low from start until result stands
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busy_n_q <= 1'b1;
      act_q <= 1'b0;
    end else if (ce) begin
      busy_n_q <= state_d == CS_IDLE;
      act_q <= state_d != CS_IDLE;
    end
  end

  // =====================================================================
  // Parallel result output
  // low byte, then upper bits
  wire [BYTE_BITS-1:0] byte_sel = hbs_s ?
    {4'h0, result_q[11:8]} : result_q[7:0];
  wire [10:0] low_d = byte_fmt ? {3'h0, byte_sel} : result_q[10:0];
  wire rd_en = cs_s & rd_s;

  // Bus drivers follow select and read
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      low_q <= '0;
      low_oe_q <= 1'b0;
      msb_q <= 1'b0;
      msb_oe_q <= 1'b0;
    end else if (ce) begin
      low_q <= low_d;
      low_oe_q <= rd_en;
      msb_q <= result_q[11];
      msb_oe_q <= rd_en & ~byte_fmt;
    end
  end

  // =====================================================================
  // Serial output engine
  wire tick = div_q == '0;
  // gated word loads before first fall
  wire gated_load = ~cont_fmt & ser_pend_q & ~ser_act_q;
  wire rise_tick = tick & ~sclk_q & (cont_fmt | ser_act_q);
  wire cont_load = rise_tick & ~ser_act_q & ser_pend_q;
  wire load = gated_load | cont_load;
  wire shift_now = rise_tick & ser_act_q;
  wire last_bit = bit_q == 4'hf;

  // Serial clock divider and level
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_q <= '0;
      sclk_q <= 1'b1;
    end else if (ce) begin
      if (gated_load || tick) begin
        div_q <= SCLK_DIV_W'(SCLK_HALF_CYC - 1);
      end else begin
        div_q <= div_q - 1'b1;
      end
      if (gated_load) begin
        sclk_q <= 1'b1;
      end else if (tick && (cont_fmt || ser_act_q)) begin
        sclk_q <= ~sclk_q;
      end else if (!cont_fmt && !ser_act_q) begin
        sclk_q <= 1'b1;
      end
    end
  end

  // Word shifter, data changes on rising clock
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ser_pend_q <= 1'b0;
      ser_act_q <= 1'b0;
      bit_q <= '0;
      shreg_q <= '0;
      serial_data_pin_q <= 1'b1;
      strb_q <= 1'b0;
    end else if (ce) begin
      if (start) begin
        ser_pend_q <= 1'b1;
        shreg_q <= {{(WORD_BITS - RES_BITS){1'b0}}, sample};
      end else if (load) begin
        ser_pend_q <= 1'b0;
      end
      if (load) begin
        ser_act_q <= 1'b1;
        bit_q <= '0;
        serial_data_pin_q <= shreg_q[WORD_BITS-1];
        strb_q <= 1'b1;
      end else if (shift_now) begin
        ser_act_q <= ~last_bit;
        bit_q <= bit_q + 1'b1;
        shreg_q <= {shreg_q[WORD_BITS-2:0], 1'b0};
        serial_data_pin_q <= shreg_q[WORD_BITS-2];
        strb_q <= 1'b0;
      end
    end
  end

  // Open-drain pin stage: enable pulls the line low
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sclk_o_q <= 1'b1;
      sclk_oe_q <= 1'b0;
      sdo_q <= 1'b1;
      sdo_oe_q <= 1'b0;
      strb_o_q <= 1'b1;
      strb_oe_q <= 1'b0;
    end else if (ce) begin
      sclk_o_q <= sclk_q;
      sclk_oe_q <= ~sclk_q;
      sdo_q <= serial_data_pin_q;
      sdo_oe_q <= ser_act_q & ~serial_data_pin_q;
      strb_o_q <= ~strb_q;
      strb_oe_q <= strb_q;
    end
  end

  // =====================================================================
  // Port drive
  assign link.conv_busy_n = busy_n_q;
  assign link.result_low_o = low_q;
  assign link.result_low_oe = low_oe_q;
  assign link.result_msb_o = msb_q;
  assign link.result_msb_oe = msb_oe_q;
  assign link.serial_clk_o = sclk_o_q;
  assign link.serial_clk_oe = sclk_oe_q;
  assign link.serial_data_out = sdo_q;
  assign link.serial_data_out_oe = sdo_oe_q;
  assign link.serial_strobe_o = strb_o_q;
  assign link.serial_strobe_oe = strb_oe_q;
  assign conversion_active = act_q;

endmodule

// *** hdl/adc_host_end.sv ***
/*
  Host end: Avalon-MM register slave that runs converter reads,
  convert pulses and standalone cycles, and receives serial words.
  Assumes converter-driven pins are asynchronous to mclk.
*/
// Added by the designer: the Avalon-MM interface to the registers and the register addresses.
module adc_host_end
  import adc_link_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  adc_link_if.host link
);

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_PULSE = 3'b001,
    H_EOC = 3'b010,
    H_READ = 3'b011,
    H_SETTLE = 3'b100,
    H_GAP = 3'b101,
    H_ALONE = 3'b110
  } host_state_e;

  host_state_e hst_q;
  logic [15:0] in_s;
  logic [1:0] fmt_q;
  logic [1:0] op_q;
  logic [1:0] mask_q;
  logic [1:0] stat_q;
  logic [RES_BITS-1:0] result_q;
  logic [WORD_BITS-1:0] ser_word_q;
  logic [WORD_BITS-1:0] rx_sh_q;
  logic [3:0] rx_cnt_q;
  logic sclk_prev_q;
  logic busy_prev_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic irq_q;
  logic [TMR_W-1:0] tmr_q;
  logic second_q;
  logic cs_n_q;
  logic rd_n_q;
  logic cvt_n_q;
  logic hbs_q;
  logic hbs_oe_q;

  // =====================================================================
  // Pin synchronisation
  sync2 #(.W(16)) u_in_sync (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .d({link.conv_busy_n, link.serial_clk, link.serial_data_pin,
        link.serial_strobe_n, link.parallel_result_bus}),
    .q(in_s)
  );

  wire busy_s = ~in_s[15];
  wire sclk_s = in_s[14];
  wire sd_s = in_s[13];
  wire strb_s = ~in_s[12];
  wire [11:0] db_s = in_s[11:0];
  wire byte_fmt = fmt_q == FMT_BYTE;
  wire cont = fmt_q == FMT_CONT;
  wire tmr_zero = tmr_q == '0;

  // =====================================================================
  // Register bus decode
  wire wr_go = avs_write & ~wait_q;
  wire sel_ctrl = avs_address == REG_CTRL;
  wire sel_stat = avs_address == REG_IRQ_STAT;
  wire [1:0] op_w = avs_writedata[CTRL_OP_LSB +: 2];
  wire go = wr_go & sel_ctrl & avs_writedata[CTRL_GO_BIT] &
    (hst_q == H_IDLE);
  wire [31:0] ctrl_rd = {26'h0, op_q, 2'h0, fmt_q};
  wire [31:0] stat_rd = {30'h0, busy_s, hst_q != H_IDLE};
  wire [31:0] rd_mux =
    (avs_address == REG_CTRL) ? ctrl_rd :
    (avs_address == REG_STATUS) ? stat_rd :
    (avs_address == REG_RESULT) ? {20'h0, result_q} :
    (avs_address == REG_SERIAL) ? {16'h0, ser_word_q} :
    sel_stat ? {30'h0, stat_q} :
    (avs_address == REG_IRQ_MASK) ? {30'h0, mask_q} : 32'h0000_0000;

  // =====================================================================
  // Serial receiver
  // sample on falling clock
  wire fall = sclk_prev_q & ~sclk_s;
  wire first = cont & strb_s;
  wire take = fall & (~cont | first | (rx_cnt_q != 4'h0));
  wire [3:0] rx_idx = first ? 4'h0 : rx_cnt_q;
  wire [WORD_BITS-1:0] rx_new = {rx_sh_q[WORD_BITS-2:0], sd_s};
  wire ser_set = take & (rx_idx == 4'hf);

  // Parallel completion events
  wire settle_end = (hst_q == H_SETTLE) & tmr_zero;
  wire par_set = (settle_end & ~(byte_fmt & ~second_q)) |
    ((hst_q == H_ALONE) & tmr_zero);
  wire [1:0] clr = (wr_go & sel_stat) ? avs_writedata[1:0] : 2'h0;
  wire [1:0] stat_d = (stat_q & ~clr) | {ser_set, par_set};

  // Bus slave, control and interrupt registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
      fmt_q <= RST_FMT;
      op_q <= RST_OP;
      mask_q <= RST_MASK;
      stat_q <= 2'h0;
      irq_q <= 1'b0;
    end else if (ce) begin
      wait_q <= ~((avs_read | avs_write) & wait_q);
      if ((avs_read | avs_write) && wait_q) begin
        rdata_q <= rd_mux;
      end
      if (wr_go && sel_ctrl) begin
        fmt_q <= avs_writedata[CTRL_FMT_LSB +: 2];
        op_q <= op_w;
      end
      if (wr_go && avs_address == REG_IRQ_MASK) begin
        mask_q <= avs_writedata[1:0];
      end
      stat_q <= stat_d;
      irq_q <= |(stat_d & mask_q);
    end
  end

  // Receive shifter and edge history
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_cnt_q <= 4'h0;
      rx_sh_q <= '0;
      ser_word_q <= '0;
      sclk_prev_q <= 1'b1;
      busy_prev_q <= 1'b0;
    end else if (ce) begin
      sclk_prev_q <= sclk_s;
      busy_prev_q <= busy_s;
      if (!cont && !busy_s) begin
        rx_cnt_q <= 4'h0;
      end else if (take) begin
        rx_cnt_q <= rx_idx + 1'b1;
        rx_sh_q <= rx_new;
      end
      if (ser_set) begin
        ser_word_q <= rx_new;
      end
    end
  end

  // =====================================================================
  // Transfer sequencer
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hst_q <= H_IDLE;
      tmr_q <= '0;
      second_q <= 1'b0;
      cs_n_q <= 1'b1;
      rd_n_q <= 1'b1;
      result_q <= '0;
    end else if (ce) begin
      if (!tmr_zero) begin
        tmr_q <= tmr_q - 1'b1;
      end
      unique case (hst_q)
        H_IDLE: begin
          if (go) begin
            second_q <= 1'b0;
            if (op_w == OP_PULSE) begin
              hst_q <= H_PULSE;
              tmr_q <= TMR_W'(CVT_PULSE_CYC - 1);
            end else if (op_w == OP_ALONE) begin
              hst_q <= H_ALONE;
              cs_n_q <= 1'b0;
              tmr_q <= TMR_W'(ALONE_CS_CYC - 1);
            end else begin
              hst_q <= H_READ;
              cs_n_q <= 1'b0;
              rd_n_q <= 1'b0;
              tmr_q <= TMR_W'(READ_SETUP_CYC - 1);
            end
          end
        end
        H_PULSE: begin
          if (tmr_zero) begin
            hst_q <= H_EOC;
            tmr_q <= TMR_W'(READ_SETUP_CYC - 1);
          end
        end
        H_EOC: begin
          if (tmr_zero && !busy_s) begin
            hst_q <= H_READ;
            cs_n_q <= 1'b0;
            rd_n_q <= 1'b0;
            tmr_q <= TMR_W'(READ_SETUP_CYC - 1);
          end
        end
        H_READ: begin
          if (tmr_zero && !busy_s) begin
            hst_q <= H_SETTLE;
            tmr_q <= TMR_W'(SETTLE_CYC - 1);
          end
        end
        H_SETTLE: begin
          if (tmr_zero) begin
            cs_n_q <= 1'b1;
            rd_n_q <= 1'b1;
            if (byte_fmt && !second_q) begin
              result_q[7:0] <= db_s[7:0];
              second_q <= 1'b1;
              hst_q <= H_GAP;
              tmr_q <= TMR_W'(GAP_CYC - 1);
            end else begin
              if (byte_fmt) begin
                result_q[11:8] <= db_s[3:0];
              end else begin
                result_q <= db_s;
              end
              hst_q <= H_IDLE;
            end
          end
        end
        H_GAP: begin
          if (tmr_zero) begin
            hst_q <= H_READ;
            cs_n_q <= 1'b0;
            rd_n_q <= 1'b0;
            tmr_q <= TMR_W'(READ_SETUP_CYC - 1);
          end
        end
        H_ALONE: begin
          rd_n_q <= ~busy_s;
          if (busy_prev_q && !busy_s) begin
            result_q <= db_s;
          end
          if (tmr_zero) begin
            cs_n_q <= 1'b1;
            rd_n_q <= 1'b1;
            hst_q <= H_IDLE;
          end
        end
        default: begin
          hst_q <= H_IDLE;
        end
      endcase
    end
  end

  // Convert pin and byte select drivers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cvt_n_q <= 1'b1;
      hbs_q <= 1'b0;
      hbs_oe_q <= 1'b0;
    end else if (ce) begin
      cvt_n_q <= (op_q == OP_PULSE) & (hst_q != H_PULSE);
      hbs_q <= second_q & ~go; // Low with select on first read
      hbs_oe_q <= byte_fmt;
    end
  end

  // =====================================================================
  // Port drive
  assign link.cs_n = cs_n_q;
  assign link.rd_n = rd_n_q;
  assign link.convert_start_n = cvt_n_q;
  assign link.fmt_sel = fmt_q;
  assign link.high_byte_select_o = hbs_q;
  assign link.high_byte_select_oe = hbs_oe_q;
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign irq = irq_q;

endmodule

// *** testbench/adc_link_assertions.sv ***
/* Pin checker for the converter link.
   Assumes one mclk domain; inputs are link interface signals. */
module adc_link_assertions
  import adc_link_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic convert_start_n,
  input wire logic [1:0] fmt_sel,
  input wire logic conv_busy_n,
  input wire logic result_low_oe,
  input wire logic serial_clk,
  input wire logic serial_data_pin,
  input wire logic serial_strobe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] busy_q;
  logic [4:0] falls_q;
  logic sclk_q;
  wire rd_act = !cs_n && !rd_n;
  wire gated = fmt_sel != FMT_CONT;
  wire fall = sclk_q && !serial_clk;
  // ==========
  // Busy time and clock falls per conversion
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busy_q <= 10'h000;
      falls_q <= 5'h00;
      sclk_q <= 1'b1;
    end else begin
      busy_q <= conv_busy_n ? 10'h000 : busy_q + 10'h001;
      falls_q <= conv_busy_n ? 5'h00 : falls_q + 5'(fall);
      sclk_q <= serial_clk;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence start_s; $rose(convert_start_n) && conv_busy_n; endsequence
  // ==========
  // Link pin relations
  busy_time_a: assert property ($rose(conv_busy_n) |->
    busy_q == 10'(CONV_CYC)) else $error("busy time");
  word_bits_a: assert property ($rose(conv_busy_n) && gated |->
    falls_q == 5'(WORD_BITS)) else $error("word length");
  first_fall_a: assert property ($fell(serial_strobe_n) && gated |->
    serial_clk ##[4:8] (fall && !serial_data_pin)) else $error("first bit");
  strobe_len_a: assert property ($fell(serial_strobe_n) |->
    ##[8:14] serial_strobe_n) else $error("strobe length");
  idle_pins_a: assert property ((conv_busy_n && fmt_sel == FMT_BYTE)[*8]
    |-> serial_clk && serial_data_pin) else $error("idle pins");
  gated_run_a: assert property (fall && gated |-> !conv_busy_n)
    else $error("clock while idle");
  read_lag_a: assert property (result_low_oe |-> $past(rd_act, 3))
    else $error("data without read");
  start_lat_a: assert property (start_s |-> ##[3:5] !conv_busy_n)
    else $error("start latency");
endmodule

// *** testbench/tb.sv ***
/* Bench: both link ends joined, host end run over Avalon-MM.
   Assumes package, interface, design and checker compiled first. */
`define CHK(n, e, g) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    err_count++; \
    $display("unexpected %s exp %h got %h", n, e, g); \
  end \
end
module tb
  import adc_link_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, rst = 1'b1, ce = 1'b1, irq, conversion_active;
  logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [2:0] avs_address = 3'h0;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, d;
  logic [RES_BITS-1:0] sample = 12'h000;
  int err_count = 0, tests_run = 0, cyc = 0;
  adc_link_if lk ();
  adc_device_end i_adc_device_end (.mclk, .rst, .ce, .link(lk), .sample,
    .conversion_active);
  adc_host_end i_adc_host_end (.mclk, .rst, .ce, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .irq,
    .link(lk));
  adc_link_assertions i_adc_link_assertions (.mclk, .rst,
    .cs_n(lk.cs_n), .rd_n(lk.rd_n), .convert_start_n(lk.convert_start_n),
    .fmt_sel(lk.fmt_sel), .conv_busy_n(lk.conv_busy_n),
    .result_low_oe(lk.result_low_oe), .serial_clk(lk.serial_clk),
    .serial_data_pin(lk.serial_data_pin),
    .serial_strobe_n(lk.serial_strobe_n));
  // ==========
  // Clock and hang guard
  initial forever #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One Avalon transfer; read data lands in d
  task automatic av(input logic w, input logic [2:0] a,
    input logic [31:0] wd);
    @(posedge mclk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= wd;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rdchk(input logic [2:0] a, input logic [31:0] e,
    input string n);
    av(1'b0, a, 32'h0000_0000);
    `CHK(n, e, d)
  endtask
  // ==========
  // Reset values, then byte read, standalone and pulse passes
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    av(1'b1, 3'h7, 32'hffff_ffff);
    for (int a = 0; a < 8; a++)
      if (a < 2 || a > 3)
        rdchk(3'(a), 32'h0000_0000, "reset value");
    for (int i = 0; i < 3; i++) begin
      logic [RES_BITS-1:0] s;
      s = 12'hfff - 12'(i * 12'h7ff);
      sample <= s;
      av(1'b1, REG_IRQ_MASK, (i == 1) ? 32'h0000_0000 : 32'h0000_0003);
      av(1'b1, REG_CTRL, {26'h0, 2'(i * 2 % 3), 2'h1, 2'(i)});
      do av(1'b0, REG_STATUS, 32'h0000_0000);
      while (d[STAT_CONV_BIT] !== 1'b1);
      `CHK("running", 1'b1, d[STAT_RUN_BIT])
      `CHK("active", 1'b1, conversion_active)
      do av(1'b0, REG_IRQ_STAT, 32'h0000_0000); while (d[0] !== 1'b1);
      rdchk(REG_RESULT, {20'h0_0000, s}, "result");
      rdchk(REG_SERIAL, {20'h0_0000, s}, "serial word");
      `CHK("irq", 1'(i != 1), irq)
      `CHK("idle", 1'b0, conversion_active)
      av(1'b1, REG_IRQ_STAT, 32'h0000_0003);
      rdchk(REG_IRQ_STAT, 32'h0000_0000, "events");
      `CHK("irq off", 1'b0, irq)
      $display("pass %0d done", i);
    end
    report_and_stop();
  end
endmodule
